//--- lcm_cell.sv
//Contract
//- mux combine gives upper function when bypass high, else lower function.
//- xor combine gives upper xor lower xor bypass.
//- nand output is inverted AND of upper, lower and bypass.
//- mux and xor combine never both drive the combine output.
//- combine only with both halves five-input; function outputs stay usable.
//- six-input function: shared inputs, bypass as sixth, result on combine output.
//- ripple carry input from fast carry, lower fifth input, one or zero.
//- ripple takes two nibbles; each quarter gives result bit and carry.
//- top carry goes to dedicated carry out, cell output four, or both.
//- adder stages propagate or generate; upper fifth input picks add or subtract.
//- counter adds or subtracts one; upper fifth input picks direction.
//- multiplier adds multiplicand when upper fifth high, else passes partial product.
//- comparator forces carry in zero; carry out is one on mismatch.
//- each half can be a 16x2 RAM while the other is logic.
//- 16x4 RAM uses both nibbles as address, fifth inputs as write enables.
//- each half write is its enable ANDed with the shared write gate.
//- the same write gate applies to both halves in memory mode.
//- ripple mode excludes any logic or memory use of the table.
//- bypass and carry input polarity invertible by configuration.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
module lcm_cell
    import lcm_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdData,
    // fabric inputs
    input  wire logic [4:0]  upperIn,
    input  wire logic [4:0]  lowerIn,
    input  wire logic        bypassIn,
    input  wire logic        fastCarryIn,
    input  wire logic [3:0]  writeDataIn,
    input  wire logic        bankEnable,
    // cell outputs
    output logic      [3:0]  funcOut,
    output logic             carryOutPort,
    output logic             cellOutFour,
    output logic      [3:0]  readBusOut,
    output logic             readBusOe
);
    logic [CFG_W-1:0] cfg_ff, nxt_cfg;
    logic [31:0]      rdWord_ff, nxt_rdWord;
    lcm_rd_t          rdKind_ff, nxt_rdKind;
    logic [3:0]       funcOut_ff, nxt_funcOut;
    logic             carryOut_ff, nxt_carryOut;
    logic             o4_ff, nxt_o4;
    logic             live_ff, nxt_live;

    logic       hiRam, loRam, ripOn, bothLogic, bypass, carryIn, wGate, carry_input_port;
    lcm_cmb_t   cmb;
    lcm_sub_t   sub;
    lcm_carry_output_port_t  coutRoute;
    logic [3:0] qOut, ramWe, sum;
    logic [15:0] tblRd;
    logic       upperFn, lowerFn, muxVal, xorVal, nandVal, ripCo, tblWr;

    // configuration fields
    assign hiRam     = cfg_ff[CFG_HI_RAM];
    assign loRam     = cfg_ff[CFG_LO_RAM];
    assign ripOn     = cfg_ff[CFG_RIP];
    assign cmb       = lcm_cmb_t'(cfg_ff[CFG_CMB +: 2]);
    assign sub       = lcm_sub_t'(cfg_ff[CFG_SUB +: 2]);
    assign coutRoute = lcm_carry_output_port_t'(cfg_ff[CFG_CARRY_OUTPUT_PORT +: 2]);
    assign bothLogic = !hiRam && !loRam && !ripOn;

    assign bypass  = bypassIn ^ cfg_ff[CFG_INV_BYP];
    assign carryIn = fastCarryIn ^ cfg_ff[CFG_INV_CIN];

    always_comb begin
        case (lcm_cin_t'(cfg_ff[CFG_CIN +: 2]))
            CIN_FAST: carry_input_port = carryIn;
            CIN_LO5:  carry_input_port = lowerIn[4];
            CIN_ONE:  carry_input_port = 1'b1;
            CIN_ZERO: carry_input_port = 1'b0;
            default:  carry_input_port = 1'b0;
        endcase
    end

    // shared gate from bypass or carry
    assign wGate = cfg_ff[CFG_GATE] ? carryIn : bypass;

    // same gate for both halves; no writes in ripple mode
    assign ramWe[1:0] = {2{hiRam | loRam}} & {2{loRam && !ripOn && lowerIn[4] && wGate}};
    assign ramWe[3:2] = {2{hiRam | loRam}} & {2{hiRam && !ripOn && upperIn[4] && wGate}};

    assign tblWr = regWr && ((regAddr & TBL_MASK) == TBL_ADDR);

    lcm_table #(
        .QW(16)
    ) uTable (
        .clk       (clk),
        .arst_n    (arst_n),
        .cfgWr     (tblWr),
        .cfgIdx    (regAddr[3:2]),
        .cfgData   (regWrData[15:0]),
        .rdIdx     (regAddr[3:2]),
        .rdData    (tblRd),
        .ramWe     (ramWe),
        .ramUpAddr (upperIn[3:0]),
        .ramLoAddr (lowerIn[3:0]),
        .ramBit    (writeDataIn),
        .upIdx     (upperIn[3:0]),
        .loIdx     (lowerIn[3:0]),
        .qOut      (qOut)
    );

    // five-input functions: fifth input picks the quarter
    assign upperFn = upperIn[4] ? qOut[3] : qOut[2];
    assign lowerFn = lowerIn[4] ? qOut[1] : qOut[0];

    // mux gate; bypass is the sixth variable
    assign muxVal  = bypass ? upperFn : lowerFn;
    assign xorVal  = upperFn ^ lowerFn ^ bypass;
    assign nandVal = ~(upperFn & lowerFn & bypass);

    lcm_ripple uRipple (
        .opA  (upperIn[3:0]),
        .opB  (lowerIn[3:0]),
        .ctl  (upperIn[4]),
        .sub  (sub),
        .carry_input_port  (carry_input_port),
        .sum  (sum),
        .carry_output_port (ripCo)
    );

    // output selection by mode
    always_comb begin
        nxt_funcOut  = 4'h0;
        nxt_carryOut = 1'b0;
        nxt_o4       = 1'b0;
        if (ripOn) begin
            nxt_funcOut = sum;
            nxt_carryOut = (coutRoute == CARRY_OUTPUT_PORT_DED) || (coutRoute == CARRY_OUTPUT_PORT_BOTH) ? ripCo : 1'b0;
            nxt_o4       = (coutRoute == CARRY_OUTPUT_PORT_O4) || (coutRoute == CARRY_OUTPUT_PORT_BOTH) ? ripCo : 1'b0;
        end else begin
            // RAM halves read two bits each
            if (hiRam) begin
                nxt_funcOut[3:2] = qOut[3:2];
            end else begin
                nxt_funcOut[3] = upperFn;
            end
            if (loRam) begin
                nxt_funcOut[1:0] = qOut[1:0];
            end else begin
                nxt_funcOut[0] = lowerFn;
            end
            // gates only when both halves are five-input logic
            if (bothLogic) begin
                nxt_funcOut[2] = nandVal;
                // an illegal combine code drives nothing
                case (cmb)
                    CMB_MUX: nxt_funcOut[1] = muxVal;
                    CMB_XOR: nxt_funcOut[1] = xorVal;
                    default: nxt_funcOut[1] = 1'b0;
                endcase
            end
        end
    end

    // register access: decode, update and read capture
    always_comb begin
        nxt_cfg    = cfg_ff;
        nxt_rdWord = 32'h0000_0000;
        nxt_rdKind = RD_NONE;
        if (regWr && regAddr == CFG_ADDR) begin
            nxt_cfg = regWrData[CFG_W-1:0];
        end
        if (regRd) begin
            if (regAddr == CFG_ADDR) begin
                nxt_rdKind = RD_WORD;
                nxt_rdWord[CFG_W-1:0] = cfg_ff;
            end else if (regAddr == STAT_ADDR) begin
                nxt_rdKind = RD_WORD;
                nxt_rdWord[STAT_F +: 4] = funcOut_ff;
                nxt_rdWord[STAT_CO]     = carryOut_ff;
                nxt_rdWord[STAT_O4]     = o4_ff;
                nxt_rdWord[STAT_BANK]   = bankEnable;
            end else if ((regAddr & TBL_MASK) == TBL_ADDR) begin
                nxt_rdKind = RD_TBL;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_ff      <= CFG_RESET;
            rdWord_ff   <= 32'h0000_0000;
            rdKind_ff   <= RD_NONE;
            funcOut_ff  <= 4'h0;
            carryOut_ff <= 1'b0;
            o4_ff       <= 1'b0;
            live_ff     <= 1'b0;
        end else begin
            cfg_ff      <= nxt_cfg;
            rdWord_ff   <= nxt_rdWord;
            rdKind_ff   <= nxt_rdKind;
            funcOut_ff  <= nxt_funcOut;
            carryOut_ff <= nxt_carryOut;
            o4_ff       <= nxt_o4;
            live_ff     <= nxt_live;
        end
    end

    // unmapped addresses read as zero
    assign regRdData = (rdKind_ff == RD_TBL) ? {16'h0000, tblRd} : rdWord_ff;

    assign funcOut      = funcOut_ff;
    assign carryOutPort = carryOut_ff;
    assign cellOutFour  = o4_ff;
    // bank enable from outside drives the tristate
    assign readBusOut   = funcOut_ff;
    assign readBusOe    = bankEnable;

    // outputs still hold reset values at the release edge, so checks wait a cycle
    assign nxt_live = 1'b1;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_mux;
        live_ff && bothLogic && cmb == CMB_MUX
            |=> funcOut[1] == $past(bypass ? upperFn : lowerFn);
    endproperty
    a_mux: assert property (p_mux) else $error("mux combine wrong");

    property p_xor;
        live_ff && bothLogic && cmb == CMB_XOR
            |=> funcOut[1] == $past(upperFn ^ lowerFn ^ bypass);
    endproperty
    a_xor: assert property (p_xor) else $error("xor combine wrong");

    property p_nand;
        live_ff && bothLogic
            |=> funcOut[2] == !($past(upperFn) && $past(lowerFn) && $past(bypass));
    endproperty
    a_nand: assert property (p_nand) else $error("nand output wrong");

    property p_excl;
        live_ff && bothLogic && cmb == CMB_BAD |=> funcOut[1] == 1'b0;
    endproperty
    a_excl: assert property (p_excl) else $error("illegal combine drove output");

    property p_fn;
        live_ff && !ripOn && !hiRam |=> funcOut[3] == $past(upperFn);
    endproperty
    a_fn: assert property (p_fn) else $error("upper function lost");

    property p_add;
        live_ff && ripOn && sub == SUB_ADD && !upperIn[4]
            |=> funcOut == $past(4'(upperIn[3:0] + lowerIn[3:0] + {3'b000, carry_input_port}));
    endproperty
    a_add: assert property (p_add) else $error("ripple sum wrong");

    property p_cnt;
        live_ff && ripOn && sub == SUB_CNT && cfg_ff[CFG_CIN +: 2] == CIN_ONE
            |=> funcOut == $past(upperIn[4] ? 4'(upperIn[3:0] - 4'h1)
                                            : 4'(upperIn[3:0] + 4'h1));
    endproperty
    a_cnt: assert property (p_cnt) else $error("counter step wrong");

    property p_cmp;
        live_ff && ripOn && sub == SUB_CMP && (coutRoute == CARRY_OUTPUT_PORT_DED || coutRoute == CARRY_OUTPUT_PORT_BOTH)
            |=> carryOutPort == ($past(upperIn[3:0]) != $past(lowerIn[3:0]));
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare carry wrong");

    property p_sub;
        live_ff && ripOn && sub == SUB_ADD && upperIn[4]
            |=> funcOut == $past(4'(upperIn[3:0] + ~lowerIn[3:0] + {3'b000, carry_input_port}));
    endproperty
    a_sub: assert property (p_sub) else $error("ripple difference wrong");

    property p_mul;
        live_ff && ripOn && sub == SUB_MUL
            |=> funcOut == $past(4'(upperIn[3:0] + (upperIn[4] ? lowerIn[3:0] : 4'h0) + {3'b000, carry_input_port}));
    endproperty
    a_mul: assert property (p_mul) else $error("multiplier step wrong");

    property p_route;
        live_ff && ripOn && coutRoute == CARRY_OUTPUT_PORT_O4
            |=> carryOutPort == 1'b0 && cellOutFour == $past(ripCo);
    endproperty
    a_route: assert property (p_route) else $error("carry routing wrong");

    property p_gate;
        !wGate || ripOn |-> ramWe == 4'h0;
    endproperty
    a_gate: assert property (p_gate) else $error("write without gate");
endmodule : lcm_cell

//--- lcm_pkg.sv
package lcm_pkg;
    // register map, byte addresses on the plain register port
    localparam logic [7:0] CFG_ADDR  = 8'h00;
    localparam logic [7:0] STAT_ADDR = 8'h04;
    localparam logic [7:0] TBL_ADDR  = 8'h10; // four quarter tables at 10,14,18,1C
    localparam logic [7:0] TBL_MASK  = 8'hF3;

    // configuration field positions
    localparam int CFG_W       = 14;
    localparam int CFG_HI_RAM  = 0;  // upper half-table as 16x2 RAM
    localparam int CFG_LO_RAM  = 1;  // lower half-table as 16x2 RAM
    localparam int CFG_CMB     = 2;  // combine select, 2 bits
    localparam int CFG_RIP     = 4;  // whole table in ripple mode
    localparam int CFG_SUB     = 5;  // ripple submode, 2 bits
    localparam int CFG_CIN     = 7;  // carry input source, 2 bits
    localparam int CFG_CARRY_OUTPUT_PORT    = 9;  // carry output routing, 2 bits
    localparam int CFG_GATE    = 11; // write gate from carry (1) or bypass (0)
    localparam int CFG_INV_BYP = 12;
    localparam int CFG_INV_CIN = 13;
    localparam logic [CFG_W-1:0] CFG_RESET = 14'h0000;

    // status field positions
    localparam int STAT_F    = 0; // function outputs, 4 bits
    localparam int STAT_CO   = 4;
    localparam int STAT_O4   = 5;
    localparam int STAT_BANK = 6;

    typedef enum logic [1:0] {
        CMB_NONE = 2'b00,
        CMB_MUX  = 2'b01,
        CMB_XOR  = 2'b10,
        CMB_BAD  = 2'b11
    } lcm_cmb_t;

    typedef enum logic [1:0] {
        SUB_ADD = 2'b00,
        SUB_CNT = 2'b01,
        SUB_MUL = 2'b10,
        SUB_CMP = 2'b11
    } lcm_sub_t;

    typedef enum logic [1:0] {
        CIN_FAST = 2'b00,
        CIN_LO5  = 2'b01,
        CIN_ONE  = 2'b10,
        CIN_ZERO = 2'b11
    } lcm_cin_t;

    typedef enum logic [1:0] {
        CARRY_OUTPUT_PORT_DED  = 2'b00,
        CARRY_OUTPUT_PORT_O4   = 2'b01,
        CARRY_OUTPUT_PORT_BOTH = 2'b10,
        CARRY_OUTPUT_PORT_OFF  = 2'b11
    } lcm_carry_output_port_t;

    typedef enum logic [1:0] {
        RD_NONE = 2'b00,
        RD_WORD = 2'b01,
        RD_TBL  = 2'b10
    } lcm_rd_t;
endpackage : lcm_pkg

//--- lcm_table.sv
// 64-bit look-up table held as four 16-bit quarter tables
module lcm_table
    import lcm_pkg::*;
#(
    parameter int QW = 16
) (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           arst_n,
    // loading from the register port
    input  wire logic           cfgWr,
    input  wire logic [1:0]     cfgIdx,
    input  wire logic [QW-1:0]  cfgData,
    input  wire logic [1:0]     rdIdx,
    output logic      [QW-1:0]  rdData,
    // user memory writes, one enable per quarter
    input  wire logic [3:0]     ramWe,
    input  wire logic [3:0]     ramUpAddr,
    input  wire logic [3:0]     ramLoAddr,
    input  wire logic [3:0]     ramBit,
    // combinational lookup
    input  wire logic [3:0]     upIdx,
    input  wire logic [3:0]     loIdx,
    output logic      [3:0]     qOut
);
    logic [QW-1:0] tbl_ff [4];
    logic [QW-1:0] nxt_tbl [4];
    logic [QW-1:0] rdData_ff;

    // quarters 0,1 form the lower half, 2,3 the upper half
    always_comb begin
        for (int q = 0; q < 4; q++) begin
            nxt_tbl[q] = tbl_ff[q];
            if (ramWe[q]) begin
                nxt_tbl[q][(q < 2) ? ramLoAddr : ramUpAddr] = ramBit[q];
            end
            // loading wins so software can always repair a table
            if (cfgWr && cfgIdx == q[1:0]) begin
                nxt_tbl[q] = cfgData;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int q = 0; q < 4; q++) begin
                tbl_ff[q] <= '0;
            end
            rdData_ff <= '0;
        end else begin
            for (int q = 0; q < 4; q++) begin
                tbl_ff[q] <= nxt_tbl[q];
            end
            rdData_ff <= tbl_ff[rdIdx];
        end
    end

    assign rdData = rdData_ff;

    // reads follow the address with no clock
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gLook
            assign qOut[g] = tbl_ff[g][(g < 2) ? loIdx : upIdx];
        end
    endgenerate
endmodule : lcm_table

//--- lcm_ripple.sv
// nibble ripple datapath, one stage per quarter table
module lcm_ripple
    import lcm_pkg::*;
(
    // operands
    input  wire logic [3:0] opA,
    input  wire logic [3:0] opB,
    input  wire logic       ctl,   // upper fifth input
    input  wire lcm_sub_t   sub,
    input  wire logic       carry_input_port,
    // results
    output logic      [3:0] sum,
    output logic            carry_output_port
);
    logic [3:0] bb;
    logic [4:0] c;
    logic       c0;

    // operand shaping per submode
    always_comb begin
        c0 = carry_input_port;
        case (sub)
            SUB_ADD: bb = ctl ? ~opB : opB;
            SUB_CNT: begin
                bb = ctl ? 4'hF : 4'h0;
                c0 = ctl ? ~carry_input_port : carry_input_port; // down: step taken as borrow
            end
            SUB_MUL: bb = ctl ? opB : 4'h0;
            SUB_CMP: begin
                bb = opB;
                c0 = 1'b0;
            end
            default: bb = opB;
        endcase
    end

    // stage zero carry has a single driver apart from the chain
    assign c[0] = c0;

    // each stage propagates or generates its carry
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : gStage
            logic p;
            assign p        = opA[i] ^ bb[i];
            assign sum[i]   = p ^ c[i];
            assign c[i+1]   = (sub == SUB_CMP) ? (c[i] | p)
                                                : ((opA[i] & bb[i]) | (p & c[i]));
        end
    endgenerate

    // down counting returns a borrow so neighbours chain alike
    assign carry_output_port = (sub == SUB_CNT && ctl) ? ~c[4] : c[4];
endmodule : lcm_ripple

//--- lcm_fabric_model.sv
// neighbouring tile and routing fabric seen from one cell
module lcm_fabric_model #(
    parameter logic BANK = 1'b1
) (
    // upper address bit from the surrounding logic
    input  wire logic       hiAddr,
    // cell read bus side
    input  wire logic [3:0] readBusOut,
    input  wire logic       readBusOe,
    // decoded controls and shared bus
    output logic            bankEn,
    output logic      [3:0] sharedBus
);
    timeunit 1ns;
    timeprecision 1ns;

    // bank decode
    // one decoded enable feeds both the read driver and the write gate
    assign bankEn = (hiAddr === BANK);

    // shared read bus
    // released bus rests at the pull-up level, never the last value
    assign sharedBus = readBusOe ? readBusOut : 4'hF;
endmodule : lcm_fabric_model

//--- logic_cell_lut_modes_tb_top.sv
module logic_cell_lut_modes_tb_top;
    import lcm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [13:0] cfg;
        logic [4:0]  up;
        logic [4:0]  lo;
        logic        byp;
        logic        fast;
        logic [3:0]  expF;
        logic        chkCo;
        logic        expCo;
    } lcm_row_t;

    // stimulus and observed signals
    logic        clk, arst_n, regWr, regRd, bypTb, useBank, fastCarryIn, hiAddr;
    logic [7:0]  regAddr;
    logic [31:0] regWrData, regRdData, rdVal;
    logic [4:0]  upperIn, lowerIn;
    logic [3:0]  writeDataIn, funcOut, readBusOut, sharedBus;
    logic        carryOutPort, cellOutFour, readBusOe, bankEn, bypassIn;
    int          miscompares, totalChecks;

    // combine, inverted bypass, then every ripple submode and carry source
    lcm_row_t rows [0:20] = '{
        '{14'h0004, 5'h01, 5'h00, 1'b1, 1'b0, 4'hE, 1'b0, 1'b0},
        '{14'h0004, 5'h01, 5'h00, 1'b0, 1'b0, 4'hC, 1'b0, 1'b0},
        '{14'h0004, 5'h00, 5'h01, 1'b0, 1'b0, 4'h7, 1'b0, 1'b0},
        '{14'h0004, 5'h01, 5'h01, 1'b1, 1'b0, 4'hB, 1'b0, 1'b0},
        '{14'h0008, 5'h01, 5'h01, 1'b1, 1'b0, 4'hB, 1'b0, 1'b0},
        '{14'h0008, 5'h01, 5'h00, 1'b0, 1'b0, 4'hE, 1'b0, 1'b0},
        '{14'h0008, 5'h00, 5'h00, 1'b1, 1'b0, 4'h6, 1'b0, 1'b0},
        '{14'h0008, 5'h01, 5'h01, 1'b0, 1'b0, 4'hD, 1'b0, 1'b0},
        '{14'h000C, 5'h01, 5'h00, 1'b1, 1'b0, 4'hC, 1'b0, 1'b0},
        '{14'h1004, 5'h01, 5'h00, 1'b0, 1'b0, 4'hE, 1'b0, 1'b0},
        '{14'h0590, 5'h09, 5'h08, 1'b0, 1'b0, 4'h1, 1'b1, 1'b1},
        '{14'h0510, 5'h0F, 5'h00, 1'b0, 1'b0, 4'h0, 1'b1, 1'b1},
        '{14'h0510, 5'h15, 5'h07, 1'b0, 1'b0, 4'hE, 1'b1, 1'b0},
        '{14'h0490, 5'h01, 5'h10, 1'b0, 1'b0, 4'h2, 1'b1, 1'b0},
        '{14'h0410, 5'h01, 5'h00, 1'b0, 1'b1, 4'h2, 1'b1, 1'b0},
        '{14'h2410, 5'h01, 5'h00, 1'b0, 1'b0, 4'h2, 1'b1, 1'b0},
        '{14'h0530, 5'h0F, 5'h00, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0},
        '{14'h0530, 5'h10, 5'h00, 1'b0, 1'b0, 4'hF, 1'b0, 1'b0},
        '{14'h05D0, 5'h13, 5'h06, 1'b0, 1'b0, 4'h9, 1'b1, 1'b0},
        '{14'h05D0, 5'h03, 5'h06, 1'b0, 1'b0, 4'h3, 1'b1, 1'b0},
        '{14'h0570, 5'h05, 5'h04, 1'b0, 1'b0, 4'hF, 1'b1, 1'b1}
    };

    // bank decode drives the bypass input during the memory tests
    assign bypassIn = useBank ? bankEn : bypTb;

    lcm_cell lcm_cell_i (
        .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .upperIn(upperIn),
        .lowerIn(lowerIn), .bypassIn(bypassIn), .fastCarryIn(fastCarryIn),
        .writeDataIn(writeDataIn), .bankEnable(bankEn), .funcOut(funcOut),
        .carryOutPort(carryOutPort), .cellOutFour(cellOutFour),
        .readBusOut(readBusOut), .readBusOe(readBusOe)
    );

    lcm_fabric_model lcm_fabric_model_i (
        .hiAddr(hiAddr), .readBusOut(readBusOut), .readBusOe(readBusOe),
        .bankEn(bankEn), .sharedBus(sharedBus)
    );

    // free-running clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results

    task automatic check(input string what, input logic [31:0] seen, exp);
        totalChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // single-cycle strobes, released at the next edge
    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1; regAddr <= a; regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : regWrite

    task automatic regRead(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regRd <= 1'b1; regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask : regRead

    // one datapath sample: inputs land, one registered cycle, then look
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    // hang guard well above the scripted run length
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        results();
    end

    initial begin
        arst_n = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 8'h00;
        regWrData = 32'h0; upperIn = 5'h00; lowerIn = 5'h00; bypTb = 1'b0;
        useBank = 1'b0; fastCarryIn = 1'b0; hiAddr = 1'b0; writeDataIn = 4'h0;
        miscompares = 0; totalChecks = 0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        regRead(CFG_ADDR, rdVal);
        check("cfg reset", rdVal, 32'h0);
        regRead(8'h08, rdVal);
        check("unmapped", rdVal, 32'h0);
        // every quarter holds a function of its bit0 input only
        for (int q = 0; q < 4; q++) regWrite(TBL_ADDR + 8'(4 * q), 32'h0000AAAA);
        regRead(8'h1C, rdVal);
        check("table q3", rdVal, 32'h0000AAAA);
        $display("reset and register test done");

        foreach (rows[i]) begin
            regWrite(CFG_ADDR, {18'h0, rows[i].cfg});
            upperIn <= rows[i].up; lowerIn <= rows[i].lo;
            bypTb <= rows[i].byp; fastCarryIn <= rows[i].fast;
            settle();
            check("funcOut", funcOut, rows[i].expF);
            if (rows[i].chkCo) begin
                check("carryOut", carryOutPort, rows[i].expCo);
                check("outFour", cellOutFour, rows[i].expCo);
            end
        end
        $display("row table done");

        // carry routed to cell output four only
        regWrite(CFG_ADDR, 32'h0310);
        upperIn <= 5'h0F; lowerIn <= 5'h00;
        settle();
        check("dedicated off", carryOutPort, 1'b0);
        check("out four only", cellOutFour, 1'b1);
        $display("carry routing test done");

        // both halves as memory, write gate from the bank decode
        useBank <= 1'b1; hiAddr <= 1'b1;
        regWrite(CFG_ADDR, 32'h0003);
        upperIn <= 5'h15; lowerIn <= 5'h15; writeDataIn <= 4'hA;
        @(posedge clk);
        upperIn <= 5'h05; lowerIn <= 5'h05;
        settle();
        check("ram word", funcOut, 4'hA);
        check("bus drive", sharedBus, 4'hA);
        // bank deselected: enables alone must not write
        hiAddr <= 1'b0; upperIn <= 5'h15; lowerIn <= 5'h15; writeDataIn <= 4'h5;
        @(posedge clk);
        upperIn <= 5'h05; lowerIn <= 5'h05;
        settle();
        check("gated", funcOut, 4'hA);
        check("bus off", readBusOe, 1'b0);
        check("bus idle", sharedBus, 4'hF);
        // gate taken from the carry input instead
        regWrite(CFG_ADDR, 32'h0803);
        fastCarryIn <= 1'b1; upperIn <= 5'h15; lowerIn <= 5'h15;
        @(posedge clk);
        upperIn <= 5'h05; lowerIn <= 5'h05;
        settle();
        check("carry gate", funcOut, 4'h5);
        // upper memory beside a lower five-input function
        regWrite(CFG_ADDR, 32'h0001);
        lowerIn <= 5'h01;
        settle();
        check("mixed", funcOut, 4'h5);
        regRead(STAT_ADDR, rdVal);
        check("status", rdVal, 32'h5);
        $display("memory test done");

        // reset again in mid-run
        @(posedge clk);
        arst_n <= 1'b0;
        #1 check("reset out", funcOut, 4'h0);
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        regRead(CFG_ADDR, rdVal);
        check("cfg rerst", rdVal, 32'h0);
        $display("second reset test done");
        results();
    end
endmodule : logic_cell_lut_modes_tb_top
